// ==== verilog/regulator_event_status_regs.sv ====
/*
 * Event and status register group of a dual buck, dual linear regulator
 * power manager, reached as an AHB-Lite slave.
 * Assumes analog monitor levels and pins arrive asynchronously; each passes
 * a two-stage synchroniser before use.
 */
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "regulator_event_status_regs.svh"

module regulator_event_status_regs
    import regulator_event_pkg::*;
#(
    parameter logic [`SHORT_COUNT_W-1:0] SHORT_CYCLES = `SHORT_COUNT_W'(`SHORT_CYCLES)
) (
    input  wire logic        clock,              // Core clock, 200 MHz
    input  wire logic        resetn,             // Asynchronous reset, active low
    input  wire logic        hsel,               // AHB slave select
    input  wire logic [31:0] haddr,              // AHB byte address
    input  wire logic [1:0]  htrans,             // AHB transfer type
    input  wire logic        hwrite,             // AHB write
    input  wire logic [2:0]  hsize,              // AHB size, word only
    input  wire logic [31:0] hwdata,             // AHB write data
    input  wire logic        hready,             // AHB bus ready
    output logic             hreadyout,          // AHB slave ready
    output logic [31:0]      hrdata,             // AHB read data
    output logic             hresp,              // AHB response, always OKAY
    input  wire logic [1:0]  buckEnabled,        // Buck enable, [1]=B [0]=A
    input  wire logic [1:0]  buckPgInvalid,      // Buck output outside window
    input  wire logic [1:0]  buckShortLow,       // Buck below short threshold
    input  wire logic [1:0]  buckCurLimit,       // Buck current limit active
    input  wire logic [1:0]  linregPgInvalid,    // Linear output outside window
    input  wire logic [1:0]  linregShortLow,     // Linear below short threshold
    input  wire logic [1:0]  linregCurLimit,     // Linear current limit active
    input  wire logic        pwrokPin,           // Power-good pin, 1 = active
    input  wire logic        extSyncClockInBad,  // External sync clock invalid
    input  wire logic        thermalShutdown,    // Die above shutdown level
    input  wire logic        thermalWarning,     // Die above warning level
    input  wire logic        inputOvervoltage,   // Input above overvoltage level
    output logic             irq                 // Level interrupt, active high
);

    main_state_t state;
    main_state_t next_state;
    pin_inputs_t rawIn;
    logic        accept;
    logic        writeNow;
    logic [3:0]  shortLevel;
    logic [3:0]  shortHit;
    logic [3:0]  pgRise;
    logic [7:0]  buckSet;
    logic [7:0]  linregSet;
    logic [7:0]  topStatus;
    logic [7:0]  buckStatus;
    logic [7:0]  pendingSummary;
    logic        buckIrq;
    logic        linregIrq;
    logic [7:0]  writeByte;

    event_flag_if buckEvt ();
    event_flag_if linregEvt ();

    event_flag_bank buckBank (
        .clock  (clock),
        .resetn (resetn),
        .evt    (buckEvt)
    );

    event_flag_bank linregBank (
        .clock  (clock),
        .resetn (resetn),
        .evt    (linregEvt)
    );

    // Filter order: 0 buck A, 1 buck B, 2 linear A, 3 linear B
    assign shortLevel = {state.syncB.linregShortLow, state.syncB.buckShortLow};

    generate
        for (genvar ch = 0; ch < 4; ch++) begin : gShort
            short_persist_filter #(
                .CYCLES (SHORT_CYCLES)
            ) shortFilter (
                .clock  (clock),
                .resetn (resetn),
                .level  (shortLevel[ch]),
                .hit    (shortHit[ch])
            );
        end
    endgenerate

    always_comb begin
        rawIn.buckEnabled       = buckEnabled;
        rawIn.buckPgInvalid     = buckPgInvalid;
        rawIn.buckShortLow      = buckShortLow;
        rawIn.buckCurLimit      = buckCurLimit;
        rawIn.linregPgInvalid   = linregPgInvalid;
        rawIn.linregShortLow    = linregShortLow;
        rawIn.linregCurLimit    = linregCurLimit;
        rawIn.pwrokPin          = pwrokPin;
        rawIn.extSyncClockInBad = extSyncClockInBad;
        rawIn.thermalShutdown   = thermalShutdown;
        rawIn.thermalWarning    = thermalWarning;
        rawIn.inputOvervoltage  = inputOvervoltage;
    end

    // A power-good event is the output leaving its valid window
    assign pgRise = {state.syncB.linregPgInvalid, state.syncB.buckPgInvalid}
                    & ~state.pgPrev;

    always_comb begin
        buckSet                     = 8'h00;
        buckSet[`BIT_B_PWROK_FLAG]  = pgRise[1];
        buckSet[`BIT_A_PWROK_FLAG]  = pgRise[0];
        buckSet[`BIT_B_SHORT_FLAG]  = shortHit[1];
        buckSet[`BIT_A_SHORT_FLAG]  = shortHit[0];
        buckSet[`BIT_B_CURLIM_FLAG] = state.syncB.buckCurLimit[1];
        buckSet[`BIT_A_CURLIM_FLAG] = state.syncB.buckCurLimit[0];
    end

    always_comb begin
        linregSet                     = 8'h00;
        linregSet[`BIT_B_PWROK_FLAG]  = pgRise[3];
        linregSet[`BIT_A_PWROK_FLAG]  = pgRise[2];
        linregSet[`BIT_B_SHORT_FLAG]  = shortHit[3];
        linregSet[`BIT_A_SHORT_FLAG]  = shortHit[2];
        linregSet[`BIT_B_CURLIM_FLAG] = state.syncB.linregCurLimit[1];
        linregSet[`BIT_A_CURLIM_FLAG] = state.syncB.linregCurLimit[0];
    end

    // Write data is valid in the data phase of an accepted write
    assign writeNow  = (state.phase == PHASE_WRITE);
    assign writeByte = hwdata[7:0];

    assign buckEvt.setEvents   = buckSet;
    assign linregEvt.setEvents = linregSet;

    // Only ones clear, and only in the used bits
    assign buckEvt.clearBits = (writeNow && state.index == `IDX_BUCK_EVENT_FLAGS)
                               ? (writeByte & `EVENT_USED_BITS) : 8'h00;
    assign linregEvt.clearBits = (writeNow && state.index == `IDX_LINREG_EVENT_FLAGS)
                                 ? (writeByte & `EVENT_USED_BITS) : 8'h00;

    always_comb begin
        topStatus                          = 8'h00;
        topStatus[`BIT_PWROK_PIN_STATE]    = state.syncB.pwrokPin;
        topStatus[`BIT_EXT_SYNC_CLOCK_BAD] = state.syncB.extSyncClockInBad;
        topStatus[`BIT_THERMAL_SHUTDOWN]   = state.syncB.thermalShutdown;
        topStatus[`BIT_THERMAL_WARNING]    = state.syncB.thermalWarning;
        topStatus[`BIT_INPUT_OVERVOLTAGE]  = state.syncB.inputOvervoltage;
    end

    always_comb begin
        buckStatus                         = 8'h00;
        buckStatus[`BIT_BUCK_B_ENABLED]    = state.syncB.buckEnabled[1];
        buckStatus[`BIT_BUCK_A_ENABLED]    = state.syncB.buckEnabled[0];
        buckStatus[`BIT_BUCK_B_PG_RAW]     = state.syncB.buckPgInvalid[1];
        buckStatus[`BIT_BUCK_A_PG_RAW]     = state.syncB.buckPgInvalid[0];
        buckStatus[`BIT_BUCK_B_CURLIM_RAW] = state.syncB.buckCurLimit[1];
        buckStatus[`BIT_BUCK_A_CURLIM_RAW] = state.syncB.buckCurLimit[0];
    end

    // Summary bits are pure functions of the banks, no state to clear
    always_comb begin
        pendingSummary                      = 8'h00;
        pendingSummary[`BIT_BUCK_PENDING]   = |buckEvt.flags;
        pendingSummary[`BIT_LINREG_PENDING] = |linregEvt.flags;
    end

    assign buckIrq   = |(buckEvt.flags & ~state.buckMask);
    assign linregIrq = |(linregEvt.flags & ~state.linregMask);

    function automatic logic [31:0] readMux(input logic [7:0] idx);
        logic [7:0] value;
        value = 8'h00;
        case (idx)
            `IDX_BUCK_EVENT_FLAGS:   value = buckEvt.flags;
            `IDX_LINREG_EVENT_FLAGS: value = linregEvt.flags;
            `IDX_TOP_LIVE_STATUS:    value = topStatus;
            `IDX_BUCK_LIVE_STATUS:   value = buckStatus;
            `IDX_BUCK_EVENT_MASK:    value = state.buckMask;
            `IDX_LINREG_EVENT_MASK:  value = state.linregMask;
            `IDX_PENDING_SUMMARY:    value = pendingSummary;
            default:                 value = 8'h00;
        endcase
        return {24'h000000, value};
    endfunction

    assign accept = hsel && htrans[1] && hready;

    always_comb begin
        next_state        = state;
        next_state.syncA  = rawIn;
        next_state.syncB  = state.syncA;
        next_state.pgPrev = {state.syncB.linregPgInvalid, state.syncB.buckPgInvalid};
        next_state.irq    = buckIrq || linregIrq;

        if (writeNow && state.index == `IDX_BUCK_EVENT_MASK) begin
            next_state.buckMask = writeByte & `EVENT_USED_BITS;
        end
        if (writeNow && state.index == `IDX_LINREG_EVENT_MASK) begin
            next_state.linregMask = writeByte & `EVENT_USED_BITS;
        end

        case (state.phase)
            PHASE_READ_WAIT: begin
                // Wait state lets a preceding write settle before sampling
                next_state.rdata = readMux(state.index);
                next_state.phase = PHASE_READ_DONE;
            end
            PHASE_IDLE,
            PHASE_WRITE,
            PHASE_READ_DONE: begin
                if (accept) begin
                    next_state.phase = hwrite ? PHASE_WRITE : PHASE_READ_WAIT;
                    if (haddr[`ADDR_MSB:`IDX_MSB+1] != '0) begin
                        next_state.index = `IDX_UNMAPPED;
                    end else begin
                        next_state.index = haddr[`IDX_MSB:`IDX_LSB];
                    end
                end else begin
                    next_state.phase = PHASE_IDLE;
                end
            end
            default: begin
                next_state.phase = PHASE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state.phase      <= PHASE_IDLE;
            state.index      <= `IDX_UNMAPPED;
            state.rdata      <= 32'h00000000;
            state.buckMask   <= `EVENT_MASK_RESET;
            state.linregMask <= `EVENT_MASK_RESET;
            state.syncA      <= '0;
            state.syncB      <= '0;
            state.pgPrev     <= 4'h0;
            state.irq        <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign hreadyout = (state.phase != PHASE_READ_WAIT);
    assign hrdata    = state.rdata;
    assign hresp     = 1'b0;
    assign irq       = state.irq;

endmodule

// ==== verilog/regulator_event_status_regs.svh ====
/*
 * Register indices, bit positions, reset values and timing constants of the
 * regulator event and status register group.
 * Assumes a 200 MHz core clock; the byte address of a register is four
 * times its index.
 */
`ifndef REGULATOR_EVENT_STATUS_REGS_SVH
`define REGULATOR_EVENT_STATUS_REGS_SVH

// Register indices
`define IDX_BUCK_EVENT_FLAGS      8'h1b
`define IDX_LINREG_EVENT_FLAGS    8'h1c
`define IDX_TOP_LIVE_STATUS       8'h1d
`define IDX_BUCK_LIVE_STATUS      8'h1e
`define IDX_BUCK_EVENT_MASK       8'h40
`define IDX_LINREG_EVENT_MASK     8'h41
`define IDX_PENDING_SUMMARY       8'h42
`define IDX_UNMAPPED              8'hff

// Index field of the AHB byte address
`define IDX_LSB                   2
`define IDX_MSB                   9
`define ADDR_MSB                  31

// Event bank layout, shared by the buck and linear-regulator banks
`define BIT_B_PWROK_FLAG          6
`define BIT_B_SHORT_FLAG          5
`define BIT_B_CURLIM_FLAG         4
`define BIT_A_PWROK_FLAG          2
`define BIT_A_SHORT_FLAG          1
`define BIT_A_CURLIM_FLAG         0
`define EVENT_USED_BITS           8'h77
`define EVENT_FLAGS_RESET         8'h00
`define EVENT_MASK_RESET          8'h00

// Top live status layout
`define BIT_PWROK_PIN_STATE       7
`define BIT_EXT_SYNC_CLOCK_BAD    4
`define BIT_THERMAL_SHUTDOWN      3
`define BIT_THERMAL_WARNING       2
`define BIT_INPUT_OVERVOLTAGE     1

// Buck live status layout
`define BIT_BUCK_B_ENABLED        7
`define BIT_BUCK_B_PG_RAW         6
`define BIT_BUCK_B_CURLIM_RAW     4
`define BIT_BUCK_A_ENABLED        3
`define BIT_BUCK_A_PG_RAW         2
`define BIT_BUCK_A_CURLIM_RAW     0

// Pending summary layout
`define BIT_BUCK_PENDING          5
`define BIT_LINREG_PENDING        6

// Short-circuit persistence time
`define SHORT_TIME_MS             1
`define CLOCK_MHZ                 200
`define SHORT_CYCLES              (`SHORT_TIME_MS * 1000 * `CLOCK_MHZ)
`define SHORT_COUNT_W             18

`endif

// ==== verilog/regulator_event_pkg.sv ====
/*
 * Types of the regulator event and status register group.
 * Assumes the constants header is on the include path.
 */
`include "regulator_event_status_regs.svh"

package regulator_event_pkg;

    typedef enum logic [3:0] {
        PHASE_IDLE      = 4'b0001,
        PHASE_WRITE     = 4'b0010,
        PHASE_READ_WAIT = 4'b0100,
        PHASE_READ_DONE = 4'b1000
    } bus_phase_t;

    typedef struct packed {
        logic [1:0] buckEnabled;
        logic [1:0] buckPgInvalid;
        logic [1:0] buckShortLow;
        logic [1:0] buckCurLimit;
        logic [1:0] linregPgInvalid;
        logic [1:0] linregShortLow;
        logic [1:0] linregCurLimit;
        logic       pwrokPin;
        logic       extSyncClockInBad;
        logic       thermalShutdown;
        logic       thermalWarning;
        logic       inputOvervoltage;
    } pin_inputs_t;

    typedef struct packed {
        bus_phase_t  phase;
        logic [7:0]  index;
        logic [31:0] rdata;
        logic [7:0]  buckMask;
        logic [7:0]  linregMask;
        pin_inputs_t syncA;
        pin_inputs_t syncB;
        logic [3:0]  pgPrev;
        logic        irq;
    } main_state_t;

    typedef struct packed {
        logic [7:0] flags;
    } bank_state_t;

    typedef struct packed {
        logic [`SHORT_COUNT_W-1:0] count;
    } filter_state_t;

endpackage

// ==== verilog/event_flag_if.sv ====
/*
 * Carrier between the register front end and one event flag bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface event_flag_if;
    logic [7:0] setEvents;
    logic [7:0] clearBits;
    logic [7:0] flags;

    modport bank  (input setEvents, input clearBits, output flags);
    modport owner (output setEvents, output clearBits, input flags);
endinterface

// ==== verilog/event_flag_bank.sv ====
/*
 * One bank of six sticky event flags in an eight-bit register, write-one-to-clear.
 * Assumes set and clear vectors come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "regulator_event_status_regs.svh"

module event_flag_bank
    import regulator_event_pkg::*;
(
    input  wire logic   clock,   // Core clock
    input  wire logic   resetn,  // Asynchronous reset, active low
    event_flag_if.bank  evt      // Set, clear and flag vectors
);

    bank_state_t state;
    bank_state_t next_state;

    // Set wins over a simultaneous clear so no event is lost
    always_comb begin
        next_state       = state;
        next_state.flags = ((state.flags & ~evt.clearBits) | evt.setEvents)
                           & `EVENT_USED_BITS;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state.flags <= `EVENT_FLAGS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign evt.flags = state.flags;

endmodule

// ==== verilog/short_persist_filter.sv ====
/*
 * Reports a level that has stayed high for more than CYCLES clock cycles.
 * Assumes the level is already synchronised to the clock.
 */
`timescale 1ns/1ps
`include "regulator_event_status_regs.svh"

module short_persist_filter
    import regulator_event_pkg::*;
#(
    parameter logic [`SHORT_COUNT_W-1:0] CYCLES = `SHORT_COUNT_W'(`SHORT_CYCLES)
) (
    input  wire logic clock,   // Core clock
    input  wire logic resetn,  // Asynchronous reset, active low
    input  wire logic level,   // Output below short threshold
    output logic      hit      // High while held past the limit
);

    filter_state_t state;
    filter_state_t next_state;

    // Counter saturates, so a long short keeps reporting without wrap
    always_comb begin
        next_state = state;
        if (!level) begin
            next_state.count = '0;
        end else if (state.count != CYCLES) begin
            next_state.count = state.count + `SHORT_COUNT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state.count <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Level sampled high on CYCLES+1 edges: strictly longer than the time
    assign hit = level && (state.count == CYCLES);

endmodule

// ==== bench/regulator_event_status_regs_chk.sv ====
/*
 * Concurrent checks on the register group's bus answers and status bits.
 * Assumes hready is tied to hreadyout and only word transfers are made.
 */
`timescale 1ns/1ps
`include "regulator_event_status_regs.svh"

module regulator_event_status_regs_chk (
    input wire logic        clock,              // Core clock
    input wire logic        resetn,             // Reset, active low
    input wire logic        hsel,               // AHB select
    input wire logic [31:0] haddr,              // AHB address
    input wire logic [1:0]  htrans,             // AHB transfer type
    input wire logic        hwrite,             // AHB write
    input wire logic        hready,             // AHB bus ready
    input wire logic        hreadyout,          // AHB slave ready
    input wire logic [31:0] hrdata,             // AHB read data
    input wire logic [1:0]  buckEnabled,        // Buck enables
    input wire logic        pwrokPin,           // Power-good pin
    input wire logic        extSyncClockInBad,  // Sync clock invalid
    input wire logic        thermalShutdown,    // Shutdown level
    input wire logic        thermalWarning,     // Warning level
    input wire logic        inputOvervoltage    // Overvoltage
);
    localparam logic [7:0] TOP = `IDX_TOP_LIVE_STATUS;
    localparam logic [7:0] BST = `IDX_BUCK_LIVE_STATUS;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence rdAny;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence rdTaken(logic [7:0] idx);
        rdAny ##0 haddr == {22'h0, idx, 2'b00};
    endsequence
    // Input held still long enough to clear the synchroniser
    property pLive(logic [7:0] idx, int b, logic s);
        ($stable(s) [*4] ##0 rdTaken(idx)) |-> ##2 (hrdata[b] == $past(s, 2));
    endproperty

    a_pwrok_live: assert property (pLive(TOP, 7, pwrokPin))
        else $error("top status bit 7 differs from pin");
    a_sync_live: assert property (pLive(TOP, 4, extSyncClockInBad))
        else $error("top status bit 4 differs from input");
    a_shutdown_live: assert property (pLive(TOP, 3, thermalShutdown))
        else $error("top status bit 3 differs from input");
    a_warning_live: assert property (pLive(TOP, 2, thermalWarning))
        else $error("top status bit 2 differs from input");
    a_overvolt_live: assert property (pLive(TOP, 1, inputOvervoltage))
        else $error("top status bit 1 differs from input");
    a_buckb_enabled: assert property (pLive(BST, 7, buckEnabled[1]))
        else $error("buck status bit 7 differs from enable");
    a_bucka_enabled: assert property (pLive(BST, 3, buckEnabled[0]))
        else $error("buck status bit 3 differs from enable");
    a_top_reserved: assert property (rdTaken(TOP) |-> ##2 (hrdata[6:5] == 2'b00 && !hrdata[0]))
        else $error("top status reserved bits nonzero");
    a_bank_reserved: assert property ((rdTaken(8'h1b) or rdTaken(8'h1c)) |-> ##2
        (!hrdata[7] && !hrdata[3])) else $error("event bank reserved bits nonzero");
    a_unmapped_zero: assert property (rdTaken(8'hff) |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits nonzero");
    a_read_wait: assert property (rdAny |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
endmodule

bind regulator_event_status_regs regulator_event_status_regs_chk u_chk (
    .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .buckEnabled(buckEnabled), .pwrokPin(pwrokPin), .extSyncClockInBad(extSyncClockInBad),
    .thermalShutdown(thermalShutdown), .thermalWarning(thermalWarning),
    .inputOvervoltage(inputOvervoltage)
);

// ==== bench/regulator_event_status_regs_test.sv ====
/*
 * Self-checking bench of the regulator event and status register group.
 * Assumes a lone AHB-Lite slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ps
`include "regulator_event_status_regs.svh"

module regulator_event_status_regs_test;
    typedef struct packed {
        logic [4:0] top;
        logic [1:0] en;
        logic [7:0] expTop;
        logic [7:0] expBuck;
    } row_t;
    // Inputs {pin, sync bad, shutdown, warning, overvoltage}, enables, results
    localparam row_t ROWS [7] = '{'{5'h10, 2'h0, 8'h80, 8'h00}, '{5'h08, 2'h1, 8'h10, 8'h08},
        '{5'h04, 2'h2, 8'h08, 8'h80}, '{5'h02, 2'h3, 8'h04, 8'h88},
        '{5'h01, 2'h0, 8'h02, 8'h00}, '{5'h1f, 2'h3, 8'h9e, 8'h88}, '{5'h00, 2'h0, 8'h00, 8'h00}};
    localparam logic [7:0] BEV = `IDX_BUCK_EVENT_FLAGS;
    localparam logic [7:0] LEV = `IDX_LINREG_EVENT_FLAGS;
    localparam logic [7:0] TOP = `IDX_TOP_LIVE_STATUS;
    localparam logic [7:0] BST = `IDX_BUCK_LIVE_STATUS;
    localparam logic [7:0] SUM = `IDX_PENDING_SUMMARY;
    localparam logic [7:0] BMK = `IDX_BUCK_EVENT_MASK;
    localparam logic [7:0] LMK = `IDX_LINREG_EVENT_MASK;

    logic        clock, resetn, hsel, hwrite, hready, hreadyout, hresp, irq, rdyQ;
    logic [31:0] haddr, hwdata, hrdata, rdQ, rd;
    logic [1:0]  htrans, buckEn;
    logic [2:0]  hsize;
    logic [11:0] ev;
    logic [4:0]  top;
    int          nMismatch, samplesChecked, cycles;

    assign hready = hreadyout;

    // Event bit i: bank i/6, kind (curlim, short, pwrok) (i%6)/2, channel i%2
    regulator_event_status_regs #(.SHORT_CYCLES(18'd20)) u_dut (
        .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .buckEnabled(buckEn),
        .buckPgInvalid(ev[5:4]), .buckShortLow(ev[3:2]), .buckCurLimit(ev[1:0]),
        .linregPgInvalid(ev[11:10]), .linregShortLow(ev[9:8]), .linregCurLimit(ev[7:6]),
        .pwrokPin(top[4]), .extSyncClockInBad(top[3]), .thermalShutdown(top[2]),
        .thermalWarning(top[1]), .inputOvervoltage(top[0]), .irq(irq));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Edge values captured so the tasks never race the design's flops
    always @(posedge clock) begin
        rdyQ <= hready;
        rdQ <= hrdata;
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            nMismatch = nMismatch + 1;
            tally_and_finish;
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do idle(1); while (rdyQ !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do idle(1); while (rdyQ !== 1'b1);
        rd = rdQ;
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkIrq(input logic exp);
        samplesChecked++;
        if (irq !== exp) begin
            nMismatch++;
            $display("MISMATCH t=%0t irq got=%h exp=%h", $time, irq, exp);
        end
    endtask

    task automatic rdChk(input logic [7:0] i, input logic [31:0] exp);
        xfer(1'b0, {22'h0, i, 2'b00}, 32'h0);
        chkWord(rd, exp);
    endtask

    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        xfer(1'b1, {22'h0, i, 2'b00}, d);
    endtask

    task automatic pulse(input int i, input int len);
        ev[i] <= 1'b1;
        idle(len);
        ev[i] <= 1'b0;
        idle(5);
    endtask

    task tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        logic [7:0]  ri;
        logic [31:0] m;
        {resetn, hsel, hwrite, haddr, htrans, hwdata, ev, top, buckEn} = '0;
        hsize = 3'b010;
        nMismatch = 0;
        samplesChecked = 0;
        cycles = 0;
        idle(3);
        resetn <= 1'b1;
        idle(4);
        rdChk(BEV, 32'h0);
        rdChk(LEV, 32'h0);
        rdChk(TOP, 32'h0);
        for (int r = 0; r < 7; r++) begin
            top <= ROWS[r].top;
            buckEn <= ROWS[r].en;
            idle(4);
            rdChk(TOP, {24'h0, ROWS[r].expTop});
            rdChk(BST, {24'h0, ROWS[r].expBuck});
        end
        // Read-only, then unmapped index and out-of-range upper address bits
        wr(TOP, 32'hff);
        wr(BST, 32'hff);
        rdChk(TOP, 32'h0);
        rdChk(BST, 32'h0);
        rdChk(8'hff, 32'h0);
        xfer(1'b0, 32'h474, 32'h0);
        chkWord(rd, 32'h0);
        chkWord({31'h0, hresp}, 32'h0);
        for (int b = 0; b < 2; b++) for (int ch = 0; ch < 2; ch++) for (int k = 0; k < 3; k++) begin
            ri = b ? LEV : BEV;
            m = 32'h1 << (ch * 4 + k);
            // Short held 21 edges, one past the 20-cycle limit
            pulse(b * 6 + k * 2 + ch, k == 1 ? 21 : 3);
            rdChk(ri, m);
            rdChk(SUM, b ? 32'h40 : 32'h20);
            chkIrq(1'b1);
            wr(ri, 32'hff ^ m);
            rdChk(ri, m);
            wr(ri, m);
            rdChk(ri, 32'h0);
            rdChk(SUM, 32'h0);
            chkIrq(1'b0);
        end
        // Held exactly the limit is not longer than it
        pulse(2, 20);
        rdChk(BEV, 32'h0);
        pulse(9, 20);
        rdChk(LEV, 32'h0);
        wr(BMK, 32'h1);
        pulse(0, 3);
        chkIrq(1'b0);
        rdChk(BEV, 32'h1);
        wr(BMK, 32'h0);
        idle(2);
        chkIrq(1'b1);
        wr(BEV, 32'h1);
        idle(2);
        chkIrq(1'b0);
        // Reserved mask bits read zero; a masked linear flag still latches
        wr(LMK, 32'hff);
        rdChk(LMK, 32'h77);
        pulse(7, 3);
        chkIrq(1'b0);
        rdChk(LEV, 32'h10);
        wr(LEV, 32'h10);
        wr(LMK, 32'h0);
        // A limit still active at the clearing write keeps its flag set
        ev[0] <= 1'b1;
        idle(4);
        rdChk(BST, 32'h1);
        wr(BEV, 32'h1);
        rdChk(BEV, 32'h1);
        ev[0] <= 1'b0;
        idle(4);
        wr(BEV, 32'h1);
        rdChk(BEV, 32'h0);
        // Reset in mid-run drops a set flag
        pulse(6, 3);
        resetn <= 1'b0;
        idle(3);
        resetn <= 1'b1;
        idle(6);
        rdChk(LEV, 32'h0);
        chkIrq(1'b0);
        tally_and_finish;
    end
endmodule
